/* hw/adc_seq_pkg.sv */
// constants, state type and register map of the adc sequencer control block
//
// Notes on behaviour
// RULE1: writing the trigger bit starts a sequence
// RULE2: new trigger aborts, restarts at first channel
// RULE3: config bit 13 selects mode, resets auto
// RULE4: direct mode converts each channel once, idles
// RULE5: auto mode loops over channels without triggers
// RULE6: trigger, mode change, channel rewrite stop cycle
// RULE7: trigger with mode zero-to-one returns to wait
// RULE8: each channel result is 10-bit straight binary
// RULE9: finished channel goes to its holding register
// RULE10: last channel copies all holdings to results
// RULE11: result reads freeze result register updates
// RULE12: config bits 9:8 set the conversion rate
// RULE13: four acquisition times plus fixed conversion time
// RULE14: auto follows rate; direct rate is a cap
// RULE15: up to 4 us sync before first channel
// RULE16: nap between conversions unless fastest rate
// RULE17: ready flag at bit 7 plus open-drain pin
// RULE18: direct completion sets ready, drives pin low
// RULE19: result read or trigger clears ready, pin
// RULE20: auto update gives 1 us low pin pulse
// RULE21: auto mode ignores trigger, reads it zero
// RULE22: host keeps bus quiet during conversion
// RULE23: ascending order, disabled channels skipped
package adc_seq_pkg;

    // -------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------
    localparam int ADDR_W = 8;      // axi byte address width
    localparam int NUM_CH = 8;      // analog channels
    localparam int RES_W = 10;      // result width
    localparam int CNT_W = 12;      // sequencer counter width

    // -------------------------------------------------------------
    // timing, ns and derived cycles at the 4 ns clock
    // -------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int ACQ_NS_0 = 375;
    localparam int ACQ_NS_1 = 2375;
    localparam int ACQ_NS_2 = 6375;
    localparam int ACQ_NS_3 = 14375;
    localparam int CONV_NS = 1625;
    localparam int SYNC_NS = 4000;  // longest start delay
    localparam int DAV_PULSE_NS = 1000;
    localparam logic [CNT_W-1:0] ACQ_CYC_0 = CNT_W'((ACQ_NS_0 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] ACQ_CYC_1 = CNT_W'((ACQ_NS_1 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] ACQ_CYC_2 = CNT_W'((ACQ_NS_2 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] ACQ_CYC_3 = CNT_W'((ACQ_NS_3 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'((CONV_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] SYNC_CYC = CNT_W'(SYNC_NS / CLK_NS);
    localparam logic [7:0] DAV_PULSE_CYC = 8'(DAV_PULSE_NS / CLK_NS);

    // -------------------------------------------------------------
    // register map, fields and reset values
    // -------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] ENA_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] GAIN_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] RES_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] RES_LAST = 8'h3c;
    localparam int TRIG_BIT = 15;
    localparam int MODE_BIT = 13;
    localparam int RATE_LSB = 8;
    localparam int READY_BIT = 7;
    localparam logic MODE_RST = 1'b1;       // auto mode
    localparam logic [1:0] RATE_FAST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SYNC,
        ST_ACQ,
        ST_CONV
    } seq_state_e;

endpackage

/* hw/adc_rate_table.sv */
// rate code to acquisition length and nap permission
`timescale 1ns/1ps
module adc_rate_table (
    input wire logic [1:0] rate,
    output logic [adc_seq_pkg::CNT_W-1:0] acq_cyc,
    output logic nap_ok
);
    import adc_seq_pkg::*;

    // -------------------------------------------------------------
    // lookup
    // -------------------------------------------------------------
    // RULE13 acquisition time table
    always_comb begin
        case (rate)
            2'h0: acq_cyc = ACQ_CYC_0;
            2'h1: acq_cyc = ACQ_CYC_1;
            2'h2: acq_cyc = ACQ_CYC_2;
            default: acq_cyc = ACQ_CYC_3;
        endcase
    end

    // RULE16 nap allowed off fastest code
    assign nap_ok = (rate != RATE_FAST);
endmodule

/* hw/adc_chan_pick.sv */
// lowest set bit finder for channel selection
`timescale 1ns/1ps
module adc_chan_pick #(
    parameter int N = 8
) (
    input wire logic [N-1:0] vec,
    output logic found,
    output logic [$clog2(N)-1:0] idx
);
    // -------------------------------------------------------------
    // priority search
    // -------------------------------------------------------------
    // RULE23 lowest enabled channel first
    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                idx = ($clog2(N))'(i);
            end
        end
    end
endmodule

/* hw/adc_sequencer_control.sv */
// adc sequencer control with axi4-lite register slave
`timescale 1ns/1ps
module adc_sequencer_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [adc_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [adc_seq_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [adc_seq_pkg::RES_W-1:0] conv_data,
    output logic [2:0] mux_sel,
    output logic track,
    output logic convert,
    output logic nap,
    output logic [adc_seq_pkg::NUM_CH-1:0] chan_gain,
    output logic data_valid_n_o,
    output logic data_valid_n_oe
);
    import adc_seq_pkg::*;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        seq_state_e st;                     // sequencer state
        logic [2:0] chan;                   // channel in work
        logic [CNT_W-1:0] cnt;              // phase countdown
        logic mode;                         // 1 auto, 0 direct
        logic [1:0] rate;                   // rate code
        logic [NUM_CH-1:0] ena;             // channel enables
        logic [NUM_CH-1:0] gain;            // channel range select
        logic [NUM_CH-1:0][RES_W-1:0] tmp;  // first stage
        logic [NUM_CH-1:0][RES_W-1:0] res;  // readable stage
        logic ready;                        // direct mode ready flag
        logic [7:0] dav_cnt;                // auto pulse timer
        logic pend;                         // copy waiting on freeze
        logic hold;                         // auto held after trig
        logic aw_ok;                        // address captured
        logic [ADDR_W-1:0] aw_addr;
        logic w_ok;                         // data captured
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rd_res;                       // result word on the bus
    } state_s;

    state_s q;
    state_s d;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    logic [CNT_W-1:0] acq_cyc;      // acquisition cycles for rate
    logic nap_ok;                   // rate code allows nap
    logic first_found;              // any channel enabled
    logic [2:0] first_idx;          // lowest enabled channel
    logic next_found;               // enabled channel above current
    logic [2:0] next_idx;
    logic [NUM_CH-1:0] above;       // enables above current chan
    logic [31:0] cfg_word;          // config readback
    logic [31:0] nv;                // merged write value
    logic wr_go;                    // write executes this cycle
    logic trig_ev;                  // accepted trigger
    logic abort_ev;                 // stop current cycle
    logic hold_ev;                  // trigger with mode 0 to 1
    logic rd_clear;                 // result read accepted
    logic done_last;                // last channel finished
    logic copy_go;                  // results copied this cycle
    logic freeze;                   // result word being shifted out
    logic set_ready;

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    adc_rate_table u_rate (.rate(q.rate), .acq_cyc(acq_cyc), .nap_ok(nap_ok));
    adc_chan_pick #(.N(NUM_CH)) u_first (.vec(q.ena), .found(first_found), .idx(first_idx));
    // mask keeps only channels above the current one
    assign above = q.ena & ~NUM_CH'((9'h2 << q.chan) - 9'h1);
    adc_chan_pick #(.N(NUM_CH)) u_next (.vec(above), .found(next_found), .idx(next_idx));

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        d = q;
        trig_ev = 1'b0;
        abort_ev = 1'b0;
        hold_ev = 1'b0;
        rd_clear = 1'b0;
        done_last = 1'b0;
        copy_go = 1'b0;
        set_ready = 1'b0;
        nv = '0;
        wr_go = q.aw_ok && q.w_ok;
        freeze = q.rvalid && q.rd_res;
        // config readback; trigger bit always reads zero
        // RULE21 trigger reads as zero
        cfg_word = '0;
        cfg_word[MODE_BIT] = q.mode;
        cfg_word[RATE_LSB +: 2] = q.rate;
        cfg_word[READY_BIT] = q.ready;

        // axi handshakes retire
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_ok = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_ok = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.rd_res = 1'b0;
        end

        // register write, once both halves are in
        if (wr_go) begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (q.aw_addr == CFG_OFS) begin
                nv = merge(cfg_word, q.w_data, q.w_strb);
                // RULE12 rate field from config write
                d.rate = nv[RATE_LSB +: 2];
                // RULE6 mode change stops cycle
                if (nv[MODE_BIT] != q.mode) begin
                    d.mode = nv[MODE_BIT];
                    abort_ev = 1'b1;
                    d.hold = 1'b0;
                    // RULE7 trigger with 0 to 1 waits
                    if (nv[TRIG_BIT] && nv[MODE_BIT]) begin
                        hold_ev = 1'b1;
                    end
                end else if (nv[TRIG_BIT] && !q.mode) begin
                    // RULE1 trigger write in direct mode
                    trig_ev = 1'b1;
                end
            end else if (q.aw_addr == ENA_OFS) begin
                // RULE6 channel rewrite stops cycle
                nv = merge({24'h0, q.ena}, q.w_data, q.w_strb);
                d.ena = nv[NUM_CH-1:0];
                abort_ev = 1'b1;
            end else if (q.aw_addr == GAIN_OFS) begin
                nv = merge({24'h0, q.gain}, q.w_data, q.w_strb);
                d.gain = nv[NUM_CH-1:0];
                abort_ev = 1'b1;
            end else if (q.aw_addr >= RES_BASE && q.aw_addr <= RES_LAST
                         && q.aw_addr[1:0] == 2'h0) begin
                d.bresp = RESP_OKAY;        // results are read only
            end else begin
                d.bresp = RESP_SLVERR;
            end
        end

        // register read
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            if (s_axi_araddr == CFG_OFS) begin
                d.rdata = cfg_word;
            end else if (s_axi_araddr == ENA_OFS) begin
                d.rdata[NUM_CH-1:0] = q.ena;
            end else if (s_axi_araddr == GAIN_OFS) begin
                d.rdata[NUM_CH-1:0] = q.gain;
            end else if (s_axi_araddr >= RES_BASE && s_axi_araddr <= RES_LAST
                         && s_axi_araddr[1:0] == 2'h0) begin
                // RULE8 10-bit result in low bits
                d.rdata[RES_W-1:0] = q.res[s_axi_araddr[4:2]];
                d.rd_res = 1'b1;
                rd_clear = 1'b1;
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end

        // sequencer
        case (q.st)
            ST_IDLE: begin
                // RULE5 auto mode starts on its own
                if (q.mode && !q.hold && first_found) begin
                    d.st = ST_SYNC;
                    d.cnt = SYNC_CYC - 1'b1;
                end
            end
            ST_SYNC: begin
                // RULE15 fixed start delay
                if (q.cnt == '0) begin
                    d.st = first_found ? ST_ACQ : ST_IDLE;
                    d.chan = first_idx;
                    d.cnt = acq_cyc - 1'b1;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_ACQ: begin
                // RULE14 rate code paces each channel
                if (q.cnt == '0) begin
                    d.st = ST_CONV;
                    d.cnt = CONV_CYC - 1'b1;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_CONV: begin
                if (q.cnt == '0) begin
                    // RULE9 result into holding register
                    d.tmp[q.chan] = conv_data;
                    // RULE23 next enabled channel upward
                    if (next_found) begin
                        d.st = ST_ACQ;
                        d.chan = next_idx;
                        d.cnt = acq_cyc - 1'b1;
                    end else begin
                        done_last = 1'b1;
                        // RULE4 direct mode goes idle
                        // RULE5 auto mode wraps to first
                        d.st = (q.mode && first_found) ? ST_ACQ : ST_IDLE;
                        d.chan = first_idx;
                        d.cnt = acq_cyc - 1'b1;
                    end
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default: d.st = ST_IDLE;
        endcase

        // aborts override the sequencer
        if (abort_ev) begin
            d.st = ST_IDLE;
        end
        if (hold_ev) begin
            d.hold = 1'b1;
        end
        // RULE2 trigger restarts from first channel
        if (trig_ev) begin
            d.st = ST_SYNC;
            d.cnt = SYNC_CYC - 1'b1;
        end

        // pulse timer runs down
        if (q.dav_cnt != '0) begin
            d.dav_cnt = q.dav_cnt - 1'b1;
        end

        // RULE11 no copy while result shifts out
        // RULE10 all holdings copied at once
        copy_go = (done_last || q.pend) && !freeze;
        if (copy_go) begin
            d.res = d.tmp;
            d.pend = 1'b0;
            if (q.mode) begin
                // RULE20 auto mode 1 us pulse
                d.dav_cnt = DAV_PULSE_CYC;
            end else begin
                set_ready = 1'b1;
            end
        end else if (done_last) begin
            d.pend = 1'b1;
        end

        // RULE19 read or trigger clears ready
        if (rd_clear || trig_ev) begin
            d.ready = 1'b0;
        end
        // RULE18 completion sets ready, set wins
        if (set_ready) begin
            d.ready = 1'b1;
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            // RULE3 auto mode after reset
            q.mode <= MODE_RST;
        end else begin
            q <= d;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign s_axi_awready = !q.aw_ok && !q.bvalid;
    assign s_axi_wready = !q.w_ok && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign mux_sel = q.chan;
    assign chan_gain = q.gain;
    assign convert = (q.st == ST_CONV);
    // RULE16 nap in idle and early acquisition
    assign nap = nap_ok && ((q.st == ST_IDLE) || (q.st == ST_ACQ && q.cnt >= ACQ_CYC_0));
    assign track = (q.st == ST_ACQ) && !nap;
    // RULE17 open-drain pin, low while enabled
    assign data_valid_n_o = 1'b0;
    assign data_valid_n_oe = q.ready || (q.dav_cnt != '0);

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_mode_after_reset: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        $rose(aresetn) |-> q.mode) else $error("mode not auto after reset");
    a_trig_restarts: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        trig_ev |=> q.st == ST_SYNC && q.cnt == SYNC_CYC - 1'b1) else $error("restart missed");
    a_chan_write_stops: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        (abort_ev && !trig_ev) |=> q.st == ST_IDLE) else $error("write did not stop cycle");
    a_trig_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
        s_axi_rvalid |-> !s_axi_rdata[TRIG_BIT]) else $error("trigger bit read back as one");
    a_freeze_results: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        freeze |=> $stable(q.res)) else $error("results changed during shift out");
    a_copy_all: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
        (q.pend && !freeze) |=> !q.pend && q.res == $past(q.tmp)) else $error("pending copy lost");
    a_ready_drives_pin: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
        (copy_go && !q.mode) |=> q.ready && data_valid_n_oe) else $error("ready not raised");
    a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
        (rd_clear && !set_ready) |=> !q.ready) else $error("result read did not clear ready");
    a_auto_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
        (copy_go && q.mode && !q.ready) |=> data_valid_n_oe [*8] ##242 data_valid_n_oe ##1
        !data_valid_n_oe) else $error("auto pulse length wrong");
    a_nap_rate: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
        nap |-> q.rate != RATE_FAST) else $error("nap at fastest rate");
    a_sync_length: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
        ($past(q.st) == ST_SYNC && q.st == ST_ACQ) |-> $past(q.cnt) == '0)
        else $error("sync ended early");

endmodule

/* tb/adc_core_model.sv */
// behavioural converter core that answers the sequencer
`timescale 1ns/1ps
module adc_core_model (
    input wire logic aclk,
    input wire logic [2:0] mux_sel,
    input wire logic convert,
    output logic [9:0] conv_data
);
    initial conv_data = 10'h155;
    always @(posedge aclk) begin
        if (convert) begin
            conv_data <= {mux_sel, 7'h2a};
        end else begin
            conv_data <= ~conv_data; // nothing valid outside conversion
        end
    end
endmodule

/* tb/tb_adc_sequencer_control.sv */
// self-checking bench of the adc sequencer control block
`timescale 1ns/1ps
module tb_adc_sequencer_control;
    import adc_seq_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rd;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, track, convert, nap, dv_o, dv_oe;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata;
    logic [9:0] conv_data;
    logic [2:0] mux_sel;
    logic [7:0] gain;
    int err_count = 0, checks_done = 0, n, busy;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_s;
    row_s rows[6] = '{
        '{0, CFG_OFS, 0, 32'h2000, 2'h0}, '{0, 8'h10, 0, 32'h0, 2'h2},
        '{1, CFG_OFS, 32'h0100, 0, 2'h0}, '{0, CFG_OFS, 0, 32'h0100, 2'h0},
        '{1, GAIN_OFS, 32'h00a5, 0, 2'h0}, '{0, GAIN_OFS, 0, 32'h00a5, 2'h0}};
    always #2 aclk = ~aclk;
    adc_sequencer_control u_adc_sequencer_control (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .conv_data(conv_data), .mux_sel(mux_sel), .track(track), .convert(convert), .nap(nap),
        .chan_gain(gain), .data_valid_n_o(dv_o), .data_valid_n_oe(dv_oe));
    adc_core_model u_adc_core_model (.aclk(aclk), .mux_sel(mux_sel), .convert(convert),
        .conv_data(conv_data));
    // verdict and end of run
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic give_up;
        err_count++;
        report_and_stop;
    endtask
    // axi write, each channel released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        b_t = 0;
        // response ends the write; valids drop at the edge that takes them
        for (n = 0; n < 100 && !b_t; n++) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            if (b_t) rs = bresp;
            @(posedge aclk);
            if (aw_t) awvalid <= 0;
            if (w_t) wvalid <= 0;
            if (b_t) bready <= 0;
        end
        if (!b_t) give_up;
    endtask
    // axi read, data taken at the rvalid edge
    task automatic rdt(input logic [7:0] a);
        logic ar_t, r_t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        r_t = 0;
        for (n = 0; n < 100 && !r_t; n++) begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            r_t = rvalid;
            if (r_t) rd = rdata;
            if (r_t) rs = rresp;
            @(posedge aclk);
            if (ar_t) arvalid <= 0;
            if (r_t) rready <= 0;
        end
        if (!r_t) give_up;
    endtask
    // bus stays idle while the converter works
    task automatic wait_dav;
        for (n = 0; n < 6000 && dv_oe !== 1'b1; n++) @(negedge aclk);
        if (n == 6000) give_up;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d); else rdt(rows[i].a);
            if (!rows[i].wr) chk(rd, rows[i].e);
            chk(32'(rs), 32'(rows[i].r));
        end
        @(negedge aclk);
        chk(32'(nap), 32'h1);
        chk(32'(gain), 32'h00a5);
        $display("register rows done");
        wr(CFG_OFS, 32'h0);
        wr(ENA_OFS, 32'h05);
        wr(CFG_OFS, 32'h8000);
        wait_dav;
        rdt(CFG_OFS);
        chk(rd, 32'h80);
        wr(CFG_OFS, 32'h8000);
        @(negedge aclk);
        chk(32'(dv_oe), 32'h0);
        wait_dav;
        chk(32'(dv_o), 32'h0);
        rdt(RES_BASE);
        chk(rd, 32'h02a);
        chk(32'(dv_oe), 32'h0);
        rdt(8'h24);
        chk(rd, 32'h0);
        rdt(8'h28);
        chk(rd, 32'h12a);
        $display("direct mode done");
        wr(CFG_OFS, 32'ha000);
        rdt(CFG_OFS);
        chk(rd, 32'h2000);
        // sequencer stays parked after trigger with mode zero-to-one
        busy = 0;
        for (n = 0; n < 1600; n++) begin
            @(negedge aclk);
            if (convert || track) busy++;
        end
        chk(busy, 32'h0);
        wr(CFG_OFS, 32'h0);
        wr(CFG_OFS, 32'h2000);
        wait_dav;
        for (n = 0; n < 400 && dv_oe === 1'b1; n++) @(negedge aclk);
        chk(n, 32'(DAV_PULSE_CYC));
        wait_dav;
        $display("auto mode done");
        // mid-run reset brings registers back to their reset values
        @(posedge aclk);
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rdt(ENA_OFS);
        chk(rd, 32'h0);
        rdt(CFG_OFS);
        chk(rd, 32'h2000);
        $display("reset test done");
        report_and_stop;
    end
endmodule
